// >>> logic/rfs_supervisor.sv
// Regulator fault supervisor with AXI4-Lite register access
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps

module rfs_supervisor
    import rfs_pkg::*;
#(
    parameter int QUAL_CYCLES    = QUAL_CYC,
    parameter int OV_EXIT_CYCLES = OV_EXIT_CYC,
    parameter int THERMAL_CYCLES = THERMAL_CYC
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire rfs_axi_req_s axi_req,
    output rfs_axi_rsp_s      axi_rsp,
    input  wire logic [3:0]   out_below_thr,   // Comparators, async
    input  wire logic         supply_ok_raw,   // Above lockout level
    input  wire logic         overvoltage_raw,
    input  wire logic         over_temp_raw,
    input  wire logic         enable_pin,
    input  wire logic         shared_pin_i,
    output logic [3:0]        reg_enable,      // Low means high impedance
    output logic [3:0]        discharge_en,
    output logic              general_out_a_o,
    output logic              general_out_a_oe,
    output logic              general_out_b_o,
    output logic              general_out_b_oe,
    output logic              external_clock_sel,
    output logic              irq_out_n
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [8:0]         sync1;     // Raw pin first stage
        logic [8:0]         sync2;
        logic               aw_v;
        logic [ADDR_W-1:0]  aw_a;
        logic               w_v;
        logic [31:0]        w_d;
        logic [3:0]         w_s;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [1:0]         rresp;
        logic [31:0]        rdata;
        logic               boot_done;
        logic               swr;
        logic [8:0]         ctrl;
        logic [6:0]         general_out_a;
        logic [10:0]        mask;
        logic [NFLAG-1:0]   flags;
        logic               en_f;
        rfs_cnt_t           en_c;
        logic               sup_f;
        rfs_cnt_t           sup_c;
        logic               ov_f;
        rfs_cnt_t           ov_c;
        logic               ts_f;
        rfs_cnt_t           ts_c;
        logic [3:0]         low_f;
        rfs_cnt_t [3:0]     low_c;
        rfs_mode_e          mode;
        logic [3:0]         run;
        logic [3:0]         dis;
        logic               ga_o;
        logic               ga_oe;
        logic               gb_o;
        logic               gb_oe;
        logic               irq_n;
    } rfs_state_s;

    rfs_state_s s_q;
    rfs_state_s s_d;

    // ----------------------------------------------------------------
    // Filter helper
    // ----------------------------------------------------------------
    // Counter runs while the sample differs from the filtered level
    function automatic logic [CNT_W:0] filt(
        input logic     raw,
        input logic     cur,
        input rfs_cnt_t cnt,
        input rfs_cnt_t rise_n,
        input rfs_cnt_t fall_n
    );
        rfs_cnt_t lim;
        lim = raw ? rise_n : fall_n;
        if (raw == cur) begin
            filt = {cur, {CNT_W{1'b0}}};
        end else if (cnt + 1'b1 >= lim) begin
            filt = {raw, {CNT_W{1'b0}}};
        end else begin
            filt = {cur, cnt + 1'b1};
        end
    endfunction

    // Merge a written word into a register under byte strobes
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  strb
    );
        logic [31:0] bm;
        bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old & ~bm) | (wd & bm);
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Signals local to the combinational process
    logic [8:0]        smp;
    logic              do_wr;
    logic              reset_cond;
    logic              blocked;
    logic              ov_hold;
    logic [NFLAG-1:0]  fset;
    logic [NFLAG-1:0]  fclr;
    logic [31:0]       bm_wd;
    logic [31:0]       stat;
    logic              lvl_a;
    logic              lvl_b;
    logic [3:0]        fault_vec;

    always_comb begin
        s_d        = s_q;
        fset       = '0;
        fclr       = '0;
        bm_wd      = '0;
        stat       = '0;
        lvl_a      = 1'b0;
        lvl_b      = 1'b0;
        fault_vec  = '0;
        // Two-stage sync of every pin; only stage two is read below
        s_d.sync1  = {shared_pin_i, enable_pin, over_temp_raw,
                      overvoltage_raw, supply_ok_raw, out_below_thr};
        s_d.sync2  = s_q.sync1;
        smp        = s_q.sync2;
        s_d.swr    = 1'b0;

        {s_d.sup_f, s_d.sup_c} = filt(smp[4], s_q.sup_f, s_q.sup_c,
                                      rfs_cnt_t'(SYNC_CYC), rfs_cnt_t'(1));
        // enable pin synchronizing delay on both edges
        {s_d.en_f, s_d.en_c} = filt(smp[7], s_q.en_f, s_q.en_c,
                                    rfs_cnt_t'(SYNC_CYC),
                                    rfs_cnt_t'(SYNC_CYC));
        if (s_q.mode == RFS_SHUTDOWN) begin
            s_d.ov_f = 1'b0;
            s_d.ov_c = '0;
        end else begin
            {s_d.ov_f, s_d.ov_c} = filt(smp[5], s_q.ov_f, s_q.ov_c,
                                        rfs_cnt_t'(OV_ENTRY_CYC),
                                        rfs_cnt_t'(OV_EXIT_CYCLES));
        end
        {s_d.ts_f, s_d.ts_c} = filt(smp[6], s_q.ts_f, s_q.ts_c,
                                    rfs_cnt_t'(THERMAL_CYCLES),
                                    rfs_cnt_t'(THERMAL_CYCLES));
        // low output must persist while running for the full time
        for (int i = 0; i < 4; i++) begin
            {s_d.low_f[i], s_d.low_c[i]} =
                filt(smp[i] & s_q.run[i], s_q.low_f[i], s_q.low_c[i],
                     rfs_cnt_t'(QUAL_CYCLES), rfs_cnt_t'(1));
        end

        // qualified low output raises short and summary flags
        for (int i = 0; i < 4; i++) begin
            if (s_d.low_f[i] && !s_q.low_f[i]) begin
                fset[FL_SHORT + i] = 1'b1;
                if (i < 2) begin
                    fset[FL_BUCK_SUM + i] = 1'b1;
                end else begin
                    fset[FL_LIN_SUM + i - 2] = 1'b1;
                end
            end
        end
        // overvoltage flag set on every cycle the condition is live
        fset[FL_OV] = s_d.ov_f;
        // thermal flag set on every cycle the condition is live
        fset[FL_TS] = s_d.ts_f;

        // Write channel: address and data taken in either order
        if (axi_req.awvalid && !s_q.aw_v && !s_q.bvalid) begin
            s_d.aw_v = 1'b1;
            s_d.aw_a = axi_req.awaddr;
        end
        if (axi_req.wvalid && !s_q.w_v && !s_q.bvalid) begin
            s_d.w_v = 1'b1;
            s_d.w_d = axi_req.wdata;
            s_d.w_s = axi_req.wstrb;
        end
        do_wr = s_q.aw_v && s_q.w_v && !s_q.bvalid;
        if (do_wr) begin
            s_d.aw_v   = 1'b0;
            s_d.w_v    = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = RESP_OKAY;
            unique case (s_q.aw_a)
                OFS_CTRL: begin
                    s_d.ctrl = 9'(merge(32'(s_q.ctrl), s_q.w_d, s_q.w_s));
                    s_d.swr  = s_d.ctrl[CT_SWRST];
                    s_d.ctrl[CT_SWRST] = 1'b0;   // Self-clearing command
                end
                OFS_GENERAL_OUT_CONTROL: begin
                    s_d.general_out_a = 7'(merge(32'(s_q.general_out_a), s_q.w_d, s_q.w_s));
                end
                OFS_MASK: begin
                    s_d.mask = 11'(merge(32'(s_q.mask), s_q.w_d, s_q.w_s));
                end
                OFS_FLAGS: begin
                    bm_wd = merge(32'h0, s_q.w_d, s_q.w_s);
                    fclr  = bm_wd[NFLAG-1:0];
                end
                OFS_STATUS: begin
                    s_d.bresp = RESP_OKAY;       // Read-only, write ignored
                end
                default: begin
                    s_d.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (s_q.bvalid && axi_req.bready) begin
            s_d.bvalid = 1'b0;
        end

        // overvoltage flag held while condition lasts
        // thermal flag held while still hot
        if (s_d.ov_f) begin
            fclr[FL_OV] = 1'b0;
        end
        if (s_d.ts_f) begin
            fclr[FL_TS] = 1'b0;
        end
        // A set in the same cycle as a clear wins
        s_d.flags = (s_q.flags & ~fclr) | fset;

        // lockout holds defaults; also soft reset and boot
        reset_cond = !s_q.boot_done || s_q.swr || !s_d.sup_f;
        if (reset_cond) begin
            s_d.boot_done = 1'b1;
            s_d.ctrl      = CTRL_RST;
            s_d.general_out_a       = GPO_RST;
            s_d.mask      = MASK_RST;
            s_d.flags     = '0;
            // reset event flagged when its default mask is clear
            s_d.flags[FL_RESET] = !MASK_RST[FL_RESET];
        end

        // enables refused while either fault is live or pending
        ov_hold = s_d.ov_f || s_d.flags[FL_OV];
        blocked = !s_d.sup_f || ov_hold || s_d.ts_f || s_d.flags[FL_TS];
        // a cleared short flag lets an enabled regulator restart
        for (int i = 0; i < 4; i++) begin
            s_d.run[i] = s_d.ctrl[CT_REQ + i] && s_d.en_f && !blocked
                         && !s_d.flags[FL_SHORT + i];
            fault_vec[i] = s_d.flags[FL_SHORT + i] || ov_hold
                           || s_d.flags[FL_TS];
        end
        // discharge all on lockout, else only on a fault-off with its bit set
        if (!s_d.sup_f) begin
            s_d.dis = 4'hf;
        end else begin
            s_d.dis = ~s_d.run & s_d.ctrl[CT_DIS +: 4] & fault_vec;
        end

        // Mode: thermal trip drops to standby as all regulators stop
        unique case (s_q.mode)
            RFS_SHUTDOWN: begin
                if (s_d.sup_f) begin
                    s_d.mode = RFS_STANDBY;
                end
            end
            RFS_STANDBY: begin
                if (!s_d.sup_f) begin
                    s_d.mode = RFS_SHUTDOWN;
                end else if (|s_d.run) begin
                    s_d.mode = RFS_ACTIVE;
                end
            end
            RFS_ACTIVE: begin
                if (!s_d.sup_f) begin
                    s_d.mode = RFS_SHUTDOWN;
                end else if (!(|s_d.run)) begin
                    s_d.mode = RFS_STANDBY;
                end
            end
            default: begin
                s_d.mode = RFS_SHUTDOWN;
            end
        endcase

        // optional gating by the enable pin sequence
        lvl_a = s_d.general_out_a[GO_A_LVL] && (!s_d.general_out_a[GO_A_SEQ] || s_d.en_f)
                && !ov_hold;
        lvl_b = s_d.general_out_a[GO_B_LVL] && (!s_d.general_out_a[GO_B_SEQ] || s_d.en_f)
                && !ov_hold;
        // open drain only pulls low, push-pull always drives
        s_d.ga_o  = s_d.general_out_a[GO_A_OD] ? 1'b0 : lvl_a;
        s_d.ga_oe = s_d.general_out_a[GO_A_OD] ? !lvl_a : 1'b1;
        // pin released when it serves as clock input
        if (s_d.general_out_a[GO_PIN_SEL]) begin
            s_d.gb_o  = 1'b0;
            s_d.gb_oe = 1'b0;
        end else begin
            s_d.gb_o  = s_d.general_out_a[GO_B_OD] ? 1'b0 : lvl_b;
            s_d.gb_oe = s_d.general_out_a[GO_B_OD] ? !lvl_b : 1'b1;
        end

        // irq low while any unmasked flag is set
        s_d.irq_n = !(|(s_d.flags & ~s_d.mask));

        // Read channel: data registered with rvalid
        stat[3:0]  = s_q.run;
        stat[4]    = s_q.ov_f;
        stat[5]    = s_q.ts_f;
        stat[6]    = s_q.sup_f;
        stat[7]    = s_q.en_f;
        stat[8]    = smp[8];
        stat[10:9] = s_q.mode;
        if (axi_req.arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = RESP_OKAY;
            unique case (axi_req.araddr)
                OFS_CTRL:     s_d.rdata = 32'(s_q.ctrl);
                OFS_GENERAL_OUT_CONTROL: s_d.rdata = 32'(s_q.general_out_a);
                OFS_MASK:     s_d.rdata = 32'(s_q.mask);
                OFS_FLAGS:    s_d.rdata = 32'(s_q.flags);
                OFS_STATUS:   s_d.rdata = stat;
                default: begin
                    s_d.rdata = '0;
                    s_d.rresp = RESP_SLVERR;
                end
            endcase
        end else if (s_q.rvalid && axi_req.rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Reset state leaves irq released until the first evaluated cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q       <= '0;
            s_q.irq_n <= 1'b1;
            s_q.ga_oe <= 1'b1;
            s_q.gb_oe <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_enable         = s_q.run;
    assign discharge_en       = s_q.dis;
    assign general_out_a_o    = s_q.ga_o;
    assign general_out_a_oe   = s_q.ga_oe;
    assign general_out_b_o    = s_q.gb_o;
    assign general_out_b_oe   = s_q.gb_oe;
    assign external_clock_sel = s_q.general_out_a[GO_PIN_SEL];
    assign irq_out_n          = s_q.irq_n;

    // Handshake outputs
    assign axi_rsp.awready = !s_q.aw_v && !s_q.bvalid;
    assign axi_rsp.wready  = !s_q.w_v && !s_q.bvalid;
    assign axi_rsp.bvalid  = s_q.bvalid;
    assign axi_rsp.bresp   = s_q.bresp;
    assign axi_rsp.arready = !s_q.rvalid;
    assign axi_rsp.rvalid  = s_q.rvalid;
    assign axi_rsp.rdata   = s_q.rdata;
    assign axi_rsp.rresp   = s_q.rresp;

endmodule

// >>> logic/rfs_pkg.sv
// Shared constants, types and register layout of the regulator fault supervisor
package rfs_pkg;

    // ----------------------------------------------------------------
    // Clock and filter timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ        = 250;
    localparam int T_QUAL_US      = 1000;   // Overload qualification, 1 ms
    localparam int T_SYNC_US      = 3;      // Enable pin and supply rise
    localparam int T_OV_ENTRY_US  = 1;
    localparam int T_OV_EXIT_US   = 20;
    localparam int T_THERMAL_US   = 20;
    localparam int QUAL_CYC       = T_QUAL_US * CLK_MHZ;
    localparam int SYNC_CYC       = T_SYNC_US * CLK_MHZ;
    localparam int OV_ENTRY_CYC   = T_OV_ENTRY_US * CLK_MHZ;
    localparam int OV_EXIT_CYC    = T_OV_EXIT_US * CLK_MHZ;
    localparam int THERMAL_CYC    = T_THERMAL_US * CLK_MHZ;
    localparam int CNT_W          = 18;

    // ----------------------------------------------------------------
    // Register map (byte addresses) and reset values
    // ----------------------------------------------------------------
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_GENERAL_OUT_CONTROL = 8'h04;
    localparam logic [7:0]  OFS_MASK     = 8'h08;
    localparam logic [7:0]  OFS_FLAGS    = 8'h0c;
    localparam logic [7:0]  OFS_STATUS   = 8'h10;
    localparam logic [8:0]  CTRL_RST     = 9'h000;
    localparam logic [6:0]  GPO_RST      = 7'h00;
    localparam logic [10:0] MASK_RST     = 11'h000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Flag bit positions
    localparam int FL_SHORT   = 0;   // 4 bits: buck0, buck1, lin0, lin1
    localparam int FL_BUCK_SUM = 4;  // 2 bits
    localparam int FL_LIN_SUM = 6;   // 2 bits
    localparam int FL_OV      = 8;
    localparam int FL_TS      = 9;
    localparam int FL_RESET   = 10;
    localparam int NFLAG      = 11;

    // General output control bit positions
    localparam int GO_A_OD    = 0;
    localparam int GO_A_LVL   = 1;
    localparam int GO_A_SEQ   = 2;
    localparam int GO_B_OD    = 3;
    localparam int GO_B_LVL   = 4;
    localparam int GO_B_SEQ   = 5;
    localparam int GO_PIN_SEL = 6;

    // Control bit positions
    localparam int CT_REQ     = 0;   // 4 bits
    localparam int CT_DIS     = 4;   // 4 bits
    localparam int CT_SWRST   = 8;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef logic [CNT_W-1:0] rfs_cnt_t;

    typedef enum logic [1:0] {
        RFS_SHUTDOWN,
        RFS_STANDBY,
        RFS_ACTIVE
    } rfs_mode_e;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } rfs_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } rfs_axi_rsp_s;

endpackage

// >>> bench/rfs_host.sv
// Host model: AXI4-Lite master that reads and clears fault flags
`timescale 1ns/10ps
module rfs_host
    import rfs_pkg::*;
(
    input  wire logic         ref_clk,
    output rfs_axi_req_s      req,
    input  wire rfs_axi_rsp_s rsp
);
    initial req = '0;

    // flags cleared by ones
    // Ready rises with the request; an idle edge first keeps calls apart
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge ref_clk);
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (rsp.bvalid) break;
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge ref_clk);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (rsp.rvalid) break;
            if (rsp.arready) req.arvalid <= 1'b0;
        end
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask
endmodule

// >>> bench/rfs_supervisor_chk.sv
// Checker of bus handshakes and fault shutdowns of the supervisor
`timescale 1ns/10ps
module rfs_supervisor_chk
    import rfs_pkg::*;
#(
    parameter int QUAL_CYCLES    = 40,
    parameter int THERMAL_CYCLES = 10
) (
    input wire logic         ref_clk,
    input wire logic         rst,
    input wire rfs_axi_req_s axi_req,
    input wire rfs_axi_rsp_s axi_rsp,
    input wire logic [3:0]   out_below_thr,
    input wire logic         supply_ok_raw,
    input wire logic         overvoltage_raw,
    input wire logic         over_temp_raw,
    input wire logic [3:0]   reg_enable,
    input wire logic [3:0]   discharge_en,
    input wire logic         general_out_a_o,
    input wire logic         general_out_a_oe,
    input wire logic         general_out_b_o
);
    int ov_n;
    int hot_n;
    int sc_n;
    // Run lengths of raw fault inputs, saturated past every filter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ov_n  <= 0;
            hot_n <= 0;
            sc_n  <= 0;
        end else begin
            ov_n  <= overvoltage_raw ? ov_n + (ov_n < 9999) : 0;
            hot_n <= over_temp_raw ? hot_n + (hot_n < 9999) : 0;
            sc_n  <= out_below_thr[0] ? sc_n + (sc_n < 9999) : 0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_wr_taken;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_ar_taken;
        axi_req.arvalid && axi_rsp.arready;
    endsequence

    a_wr_answer: assert property (s_wr_taken |-> ##2 axi_rsp.bvalid)
        else $error("write answer late");
    a_rd_answer: assert property (s_ar_taken |=> axi_rsp.rvalid && !axi_rsp.arready)
        else $error("read answer wrong");
    a_b_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=>
        axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("bresp dropped");
    a_r_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=>
        axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("rdata dropped");
    a_ov_off: assert property (ov_n >= 262 |-> reg_enable == 4'h0 &&
        !general_out_a_o && !general_out_b_o) else $error("overvoltage missed");
    a_hot_off: assert property (hot_n >= THERMAL_CYCLES + 8 |->
        reg_enable == 4'h0) else $error("thermal missed");
    a_short_off: assert property (sc_n >= QUAL_CYCLES + 8 |->
        !reg_enable[0]) else $error("short missed");
    a_lock_off: assert property ($fell(supply_ok_raw) |-> ##[1:5]
        (reg_enable == 4'h0 && discharge_en == 4'hf)) else $error("lockout");
    a_od_drive: assert property (!general_out_a_oe |->
        !general_out_a_o) else $error("open drain drives high");
endmodule

bind rfs_supervisor rfs_supervisor_chk #(.QUAL_CYCLES(QUAL_CYCLES),
    .THERMAL_CYCLES(THERMAL_CYCLES)) i_rfs_supervisor_chk (
    .ref_clk(ref_clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .out_below_thr(out_below_thr), .supply_ok_raw(supply_ok_raw),
    .overvoltage_raw(overvoltage_raw), .over_temp_raw(over_temp_raw),
    .reg_enable(reg_enable), .discharge_en(discharge_en),
    .general_out_a_o(general_out_a_o), .general_out_a_oe(general_out_a_oe),
    .general_out_b_o(general_out_b_o));

// >>> bench/test_rfs_supervisor.sv
// Self-checking bench of the regulator fault supervisor
`timescale 1ns/10ps
module test_rfs_supervisor import rfs_pkg::*;;
    localparam int QC = 40;
    localparam int OC = 20;
    localparam int TC = 10;
    logic         ref_clk = 1'b0;
    logic         rst = 1'b1;
    rfs_axi_req_s axi_req;
    rfs_axi_rsp_s axi_rsp;
    logic [3:0]   out_below_thr = 4'h0;
    logic         supply_ok_raw = 1'b0;
    logic         overvoltage_raw = 1'b0;
    logic         over_temp_raw = 1'b0;
    logic         en_pin = 1'b1;
    logic [3:0]   reg_enable;
    logic [3:0]   discharge_en;
    logic         go_a, go_a_oe, go_b, go_b_oe, clk_sel, irq_out_n;
    logic [31:0]  rd_d;
    logic [1:0]   rsp_c;
    int           fails = 0;
    int           checks = 0;
    int           cyc_n = 0;

    always #2 ref_clk = ~ref_clk;

    rfs_supervisor #(.QUAL_CYCLES(QC), .OV_EXIT_CYCLES(OC),
        .THERMAL_CYCLES(TC)) i_rfs_supervisor (
        .ref_clk(ref_clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .out_below_thr(out_below_thr), .supply_ok_raw(supply_ok_raw),
        .overvoltage_raw(overvoltage_raw), .over_temp_raw(over_temp_raw),
        .enable_pin(en_pin), .shared_pin_i(1'b0), .reg_enable(reg_enable),
        .discharge_en(discharge_en), .general_out_a_o(go_a),
        .general_out_a_oe(go_a_oe), .general_out_b_o(go_b),
        .general_out_b_oe(go_b_oe), .external_clock_sel(clk_sel),
        .irq_out_n(irq_out_n));
    rfs_host i_rfs_host (.ref_clk(ref_clk), .req(axi_req), .rsp(axi_rsp));

    task automatic chk(input string n, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_rfs_host.wr(a, d, rsp_c);
    endtask
    task automatic rd(input logic [7:0] a);
        i_rfs_host.rd(a, rd_d, rsp_c);
    endtask

    task automatic t_boot;
        cyc(800);
        chk("irq", 32'h0, 32'(irq_out_n));
        rd(OFS_FLAGS);
        chk("flags", 32'h400, rd_d);
        rd(OFS_STATUS);
        chk("status", 32'h2c0, rd_d);
        rd(8'h40);
        chk("resp", 32'(RESP_SLVERR), 32'(rsp_c));
        wr(OFS_FLAGS, 32'h400);
        cyc(2);
        chk("irq", 32'h1, 32'(irq_out_n));
        $display("boot test ended");
    endtask

    task automatic t_short;
        wr(OFS_CTRL, 32'hff);
        for (int i = 0; i < 4; i++) begin
            cyc(5);
            chk("run", 32'hf, 32'(reg_enable));
            out_below_thr <= 4'(1 << i);
            cyc(QC + 12);
            chk("run", 32'(4'hf & ~(4'h1 << i)), 32'(reg_enable));
            chk("dis", 32'(4'h1 << i), 32'(discharge_en));
            chk("irq", 32'h0, 32'(irq_out_n));
            rd(OFS_FLAGS);
            chk("flags", 32'h11 << i, rd_d);
            rd(OFS_STATUS);
            chk("stat", 32'(4'hf & ~(4'h1 << i)), 32'(rd_d[3:0]));
            out_below_thr <= 4'h0;
            wr(OFS_FLAGS, 32'h11 << i);
        end
        $display("short test ended");
    endtask

    task automatic t_ovp;
        wr(OFS_GENERAL_OUT_CONTROL, 32'h13);
        cyc(3);
        chk("gpo", 32'h6, 32'({go_a, go_a_oe, go_b, go_b_oe, clk_sel}));
        overvoltage_raw <= 1'b1;
        cyc(300);
        chk("run", 32'h0, 32'(reg_enable));
        chk("dis", 32'hf, 32'(discharge_en));
        chk("gpo", 32'h0, 32'({go_a, go_b}));
        wr(OFS_FLAGS, 32'h100);
        rd(OFS_FLAGS);
        chk("flags", 32'h100, rd_d);
        rd(OFS_STATUS);
        chk("live", 32'h1, 32'(rd_d[4]));
        overvoltage_raw <= 1'b0;
        cyc(OC + 20);
        chk("run", 32'h0, 32'(reg_enable));
        wr(OFS_FLAGS, 32'h100);
        cyc(3);
        chk("run", 32'hf, 32'(reg_enable));
        $display("overvoltage test ended");
    endtask

    task automatic t_hot;
        over_temp_raw <= 1'b1;
        cyc(TC + 10);
        chk("run", 32'h0, 32'(reg_enable));
        rd(OFS_STATUS);
        chk("mode", 32'h1, 32'(rd_d[10:9]));
        chk("live", 32'h1, 32'(rd_d[5]));
        wr(OFS_FLAGS, 32'h200);
        chk("irq", 32'h0, 32'(irq_out_n));
        over_temp_raw <= 1'b0;
        cyc(TC + 10);
        chk("run", 32'h0, 32'(reg_enable));
        wr(OFS_FLAGS, 32'h200);
        cyc(3);
        chk("irq", 32'h1, 32'(irq_out_n));
        chk("run", 32'hf, 32'(reg_enable));
        $display("thermal test ended");
    endtask

    // enable pin gates regulators and a following output
    task automatic t_seq;
        wr(OFS_GENERAL_OUT_CONTROL, 32'h46);
        en_pin <= 1'b0;
        cyc(SYNC_CYC + 10);
        chk("seq", 32'h01, 32'({reg_enable, go_a, go_b_oe, clk_sel}));
        en_pin <= 1'b1;
        cyc(SYNC_CYC + 10);
        chk("seq", 32'h7d, 32'({reg_enable, go_a, go_b_oe, clk_sel}));
        $display("sequence test ended");
    endtask

    task automatic t_lock;
        supply_ok_raw <= 1'b0;
        cyc(6);
        chk("dis", 32'hf, 32'(discharge_en));
        supply_ok_raw <= 1'b1;
        cyc(800);
        rd(OFS_CTRL);
        chk("ctrl", 32'(CTRL_RST), rd_d);
        rd(OFS_FLAGS);
        chk("flags", 32'h400, rd_d);
        wr(OFS_FLAGS, 32'h400);
        wr(OFS_CTRL, 32'h100);
        rd(OFS_FLAGS);
        chk("swrst", 32'h400, rd_d);
        wr(OFS_MASK, 32'h400);
        chk("irq", 32'h1, 32'(irq_out_n));
        $display("lockout test ended");
    endtask

    task automatic conclude;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge ref_clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        rst           <= 1'b0;
        supply_ok_raw <= 1'b1;
        t_boot();
        t_short();
        t_ovp();
        t_hot();
        t_seq();
        t_lock();
        conclude();
    end
endmodule
